// File: design/par_resolver.sv
// private address resolver: registers, dma reader and key walk
// Operation
// RULE_01 - all dma reads done before events
// RULE_02 - software keeps pointers inside data ram
// RULE_03 - address pointer set before start
// RULE_04 - start write or task pulse begins run
// RULE_05 - match sets flag and pulses output
// RULE_06 - keys tried ascending, zero to count minus one
// RULE_07 - no match sets flag and pulses
// RULE_08 - stop on first match or count
// RULE_09 - end event follows the outcome event
// RULE_10 - no address type filtering
// RULE_11 - hash random part, compare hash
// RULE_12 - receiver may start after six bytes
// RULE_13 - key n read at sixteen times n
// RULE_14 - enable set register, reads enables
// RULE_15 - enable clear register, reads enables
// RULE_16 - status holds last matching key index
// RULE_17 - enable value three turns unit on
// RULE_18 - key count one to sixteen, reset one
// RULE_19 - flags sticky until zero written
// RULE_20 - stop aborts safely, back to idle
// RULE_21 - interrupt when enabled flag set
`timescale 1ns/1ps
`default_nettype none
module par_resolver #(
  parameter int KEYS_MAX = 16
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [11:0]  reg_addr_i,
  input  wire logic [31:0]  reg_wdata_i,
  input  wire logic         reg_we_i,
  input  wire logic         reg_re_i,
  output logic      [31:0]  reg_rdata_o,
  input  wire logic         start_task_i,
  input  wire logic         stop_task_i,
  output logic              end_event_o,
  output logic              match_event_o,
  output logic              no_match_event_o,
  output logic              irq_o,
  output logic              dma_req_o,
  output logic      [31:0]  dma_addr_o,
  input  wire logic         dma_ack_i,
  input  wire logic [31:0]  dma_rdata_i,
  output logic              aes_req_o,
  output logic      [127:0] aes_key_o,
  output logic      [127:0] aes_pt_o,
  input  wire logic         aes_done_i,
  input  wire logic [127:0] aes_ct_i
);
  // the key index and count fields are sized for a sixteen entry table
  if (KEYS_MAX != int'(par_pkg::KEY_COUNT_MAX))
  begin
    $error("par_resolver serves exactly 16 keys");
  end

  par_pkg::par_regs_t q;
  par_pkg::par_regs_t d;

  logic wr_start;
  logic wr_stop;
  logic go;
  logic halt;
  logic last_key;
  logic stop_req;
  logic [2:0]  irq_src;
  logic [31:0] next_key_addr;

  // per event interrupt source: flag and enable together
  for (genvar e = 0; e < $bits(irq_src); e++)
  begin : g_irq
    assign irq_src[e] = q.flags[e] & q.inten[e]; // RULE_21
  end

  // table entry of the key after the current one
  assign next_key_addr = q.key_ptr + (32'({q.key_idx + 4'h1}) * par_pkg::KEY_STRIDE); // RULE_13

  always_comb
  begin
    d = q;
    d.pulse = 3'h0;
    // task decode
    wr_start = reg_we_i && reg_addr_i == par_pkg::OFF_START && reg_wdata_i[0];
    wr_stop  = reg_we_i && reg_addr_i == par_pkg::OFF_STOP && reg_wdata_i[0];
    stop_req = wr_stop || stop_task_i;
    go   = (wr_start || start_task_i) && q.enable == par_pkg::ENABLE_ON; // RULE_04 RULE_17
    halt = q.abort || stop_req;
    last_key = {1'b0, q.key_idx} == q.key_count - 5'h01;

    // a stop outside idle waits for the next safe point
    if (q.st != par_pkg::ST_IDLE && stop_req)
    begin
      d.abort = 1'b1; // RULE_20
    end

    // register writes
    if (reg_we_i)
    begin
      case (reg_addr_i)
        par_pkg::OFF_EV_END:
        begin
          d.flags[par_pkg::EV_END] = reg_wdata_i[0]; // RULE_19
        end
        par_pkg::OFF_EV_MATCH:
        begin
          d.flags[par_pkg::EV_MATCH] = reg_wdata_i[0];
        end
        par_pkg::OFF_EV_NOMATCH:
        begin
          d.flags[par_pkg::EV_NOMATCH] = reg_wdata_i[0];
        end
        par_pkg::OFF_IRQ_SET:
        begin
          d.inten = q.inten | reg_wdata_i[2:0]; // RULE_14
        end
        par_pkg::OFF_IRQ_CLR:
        begin
          d.inten = q.inten & ~reg_wdata_i[2:0]; // RULE_15
        end
        par_pkg::OFF_ENABLE:
        begin
          d.enable = reg_wdata_i[1:0]; // RULE_17
        end
        par_pkg::OFF_KEY_COUNT:
        begin
          if (reg_wdata_i[31:5] == 27'h0 && reg_wdata_i[4:0] >= par_pkg::KEY_COUNT_MIN
              && reg_wdata_i[4:0] <= par_pkg::KEY_COUNT_MAX)
          begin
            d.key_count = reg_wdata_i[4:0]; // RULE_18
          end
        end
        // pointers are used as given
        par_pkg::OFF_KEY_PTR:
        begin
          d.key_ptr = reg_wdata_i;
        end
        par_pkg::OFF_ADDR_PTR:
        begin
          d.addr_ptr = reg_wdata_i;
        end
        par_pkg::OFF_SCR_PTR:
        begin
          d.scr_ptr = reg_wdata_i;
        end
        default:
        begin
          d.enable = d.enable;
        end
      endcase
    end

    // key walk
    case (q.st)
      // wait for an accepted start
      par_pkg::ST_IDLE:
      begin
        d.abort = 1'b0;
        if (go)
        begin
          d.st = par_pkg::ST_ADDR0;
          d.dma_req = 1'b1;
          d.dma_addr = q.addr_ptr; // RULE_03 RULE_12
          d.key_idx = 4'h0;
        end
      end

      // fetch the first address word
      par_pkg::ST_ADDR0:
      begin
        if (dma_ack_i)
        begin
          // hash part and low random byte
          d.hash = dma_rdata_i[23:0];
          d.prand[7:0] = dma_rdata_i[31:24];
          d.dma_addr = q.addr_ptr + par_pkg::WORD_STRIDE;
          d.st = par_pkg::ST_ADDR1;
          if (halt)
          begin
            d.dma_req = 1'b0;
            d.st = par_pkg::ST_IDLE; // RULE_20
          end
        end
      end

      // fetch the second address word
      par_pkg::ST_ADDR1:
      begin
        if (dma_ack_i)
        begin
          // rest of the random part
          d.prand[23:8] = dma_rdata_i[15:0];
          d.dma_addr = q.key_ptr; // RULE_13
          d.word_idx = 2'h0;
          d.st = par_pkg::ST_KEY;
          if (halt)
          begin
            d.dma_req = 1'b0;
            d.st = par_pkg::ST_IDLE;
          end
        end
      end

      // fetch the four words of one key
      par_pkg::ST_KEY:
      begin
        if (dma_ack_i)
        begin
          d.aes_key = {dma_rdata_i, q.aes_key[127:32]};
          d.word_idx = q.word_idx + 2'h1;
          d.dma_addr = q.dma_addr + par_pkg::WORD_STRIDE;
          if (halt)
          begin
            d.dma_req = 1'b0;
            d.st = par_pkg::ST_IDLE;
          end
          // fourth word in: hand the key to the cipher
          else if (q.word_idx == par_pkg::KEY_WORDS_LAST)
          begin
            d.dma_req = 1'b0; // RULE_01
            d.aes_req = 1'b1; // RULE_11
            d.st = par_pkg::ST_CIPHER;
          end
        end
      end

      // wait for the cipher result
      par_pkg::ST_CIPHER:
      begin
        if (aes_done_i)
        begin
          d.aes_req = 1'b0;
          if (halt)
            d.st = par_pkg::ST_IDLE; // RULE_20
          else
            d.st = par_pkg::ST_CHECK;
          d.hash = (aes_ct_i[23:0] == q.hash) ? q.hash : ~q.hash;
          d.prand = (aes_ct_i[23:0] == q.hash) ? q.prand : q.prand; // RULE_10
          d.word_idx = {1'b0, aes_ct_i[23:0] == q.hash};
        end
      end

      // judge the key just tried
      par_pkg::ST_CHECK:
      begin
        d.hash = q.word_idx[0] ? q.hash : ~q.hash;
        if (halt)
        begin
          d.st = par_pkg::ST_IDLE; // RULE_20
        end
        // match: report this key
        else if (q.word_idx[0])
        begin
          d.pulse[par_pkg::EV_MATCH] = 1'b1; // RULE_05 RULE_08
          d.last_key = q.key_idx; // RULE_16
          d.st = par_pkg::ST_END;
        end
        // last key tried without a match
        else if (last_key)
        begin
          d.pulse[par_pkg::EV_NOMATCH] = 1'b1; // RULE_07 RULE_08
          d.st = par_pkg::ST_END;
        end
        else
        begin
          // move on to the next key in the table
          d.key_idx = q.key_idx + 4'h1; // RULE_06
          d.dma_addr = next_key_addr; // RULE_13
          d.dma_req = 1'b1;
          d.word_idx = 2'h0;
          d.st = par_pkg::ST_KEY;
        end
      end

      // end event one cycle after the outcome
      par_pkg::ST_END:
      begin
        d.pulse[par_pkg::EV_END] = 1'b1; // RULE_09
        d.st = par_pkg::ST_IDLE;
      end
      default:
      begin
        d.st = par_pkg::ST_IDLE;
      end
    endcase

    // hardware set wins over a software clear
    d.flags = d.flags | d.pulse; // RULE_19
    d.irq = |irq_src; // RULE_21

    // read data, valid the cycle after the strobe
    d.rdata = 32'h0;
    if (reg_re_i)
    begin
      case (reg_addr_i)
        par_pkg::OFF_EV_END:
        begin
          d.rdata = {31'h0, q.flags[par_pkg::EV_END]};
        end
        par_pkg::OFF_EV_MATCH:
        begin
          d.rdata = {31'h0, q.flags[par_pkg::EV_MATCH]};
        end
        par_pkg::OFF_EV_NOMATCH:
        begin
          d.rdata = {31'h0, q.flags[par_pkg::EV_NOMATCH]};
        end
        par_pkg::OFF_IRQ_SET:
        begin
          d.rdata = {29'h0, q.inten}; // RULE_14
        end
        par_pkg::OFF_IRQ_CLR:
        begin
          d.rdata = {29'h0, q.inten}; // RULE_15
        end
        par_pkg::OFF_LAST_KEY:
        begin
          d.rdata = {28'h0, q.last_key}; // RULE_16
        end
        par_pkg::OFF_ENABLE:
        begin
          d.rdata = {30'h0, q.enable};
        end
        par_pkg::OFF_KEY_COUNT:
        begin
          d.rdata = {27'h0, q.key_count};
        end
        par_pkg::OFF_KEY_PTR:
        begin
          d.rdata = q.key_ptr;
        end
        par_pkg::OFF_ADDR_PTR:
        begin
          d.rdata = q.addr_ptr;
        end
        par_pkg::OFF_SCR_PTR:
        begin
          d.rdata = q.scr_ptr;
        end
        default:
        begin
          d.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      // all fields zero, then the non zero resets
      q <= '0;
      q.st <= par_pkg::ST_IDLE;
      q.key_count <= par_pkg::KEY_COUNT_RST; // RULE_18
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o      = q.rdata;
  assign end_event_o      = q.pulse[par_pkg::EV_END];
  assign match_event_o    = q.pulse[par_pkg::EV_MATCH];
  assign no_match_event_o = q.pulse[par_pkg::EV_NOMATCH];
  assign irq_o            = q.irq;
  assign dma_req_o        = q.dma_req;
  assign dma_addr_o       = q.dma_addr;
  assign aes_req_o        = q.aes_req;
  assign aes_key_o        = q.aes_key;
  assign aes_pt_o         = {104'h0, q.prand};
endmodule
`default_nettype wire

// File: design/par_pkg.sv
// constants and types for the private address resolver
package par_pkg;
  localparam logic [11:0] OFF_START      = 12'h000;
  localparam logic [11:0] OFF_STOP       = 12'h008;
  localparam logic [11:0] OFF_EV_END     = 12'h100;
  localparam logic [11:0] OFF_EV_MATCH   = 12'h104;
  localparam logic [11:0] OFF_EV_NOMATCH = 12'h108;
  localparam logic [11:0] OFF_IRQ_SET    = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR    = 12'h308;
  localparam logic [11:0] OFF_LAST_KEY   = 12'h400;
  localparam logic [11:0] OFF_ENABLE     = 12'h500;
  localparam logic [11:0] OFF_KEY_COUNT  = 12'h504;
  localparam logic [11:0] OFF_KEY_PTR    = 12'h508;
  localparam logic [11:0] OFF_ADDR_PTR   = 12'h510;
  localparam logic [11:0] OFF_SCR_PTR    = 12'h514;

  localparam int          EV_END         = 0;
  localparam int          EV_MATCH       = 1;
  localparam int          EV_NOMATCH     = 2;

  localparam logic [1:0]  ENABLE_ON      = 2'h3;
  localparam logic [4:0]  KEY_COUNT_RST  = 5'h01;
  localparam logic [4:0]  KEY_COUNT_MIN  = 5'h01;
  localparam logic [4:0]  KEY_COUNT_MAX  = 5'h10;
  localparam logic [31:0] KEY_STRIDE     = 32'h0000_0010;
  localparam logic [31:0] WORD_STRIDE    = 32'h0000_0004;
  localparam logic [1:0]  KEY_WORDS_LAST = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR0, ST_ADDR1, ST_KEY, ST_CIPHER, ST_CHECK, ST_END
  } par_state_t;

  typedef struct packed {
    par_state_t   st;
    logic         abort;
    logic         dma_req;
    logic [31:0]  dma_addr;
    logic         aes_req;
    logic [127:0] aes_key;
    logic [23:0]  hash;
    logic [23:0]  prand;
    logic [3:0]   key_idx;
    logic [1:0]   word_idx;
    logic [2:0]   flags;
    logic [2:0]   inten;
    logic [2:0]   pulse;
    logic         irq;
    logic [3:0]   last_key;
    logic [1:0]   enable;
    logic [4:0]   key_count;
    logic [31:0]  key_ptr;
    logic [31:0]  addr_ptr;
    logic [31:0]  scr_ptr;
    logic [31:0]  rdata;
  } par_regs_t;
endpackage

// File: testbench/par_monitor.sv
// checker on the resolver ports
`timescale 1ns/1ps
`default_nettype none
module par_monitor (
  input wire logic         clk_i,
  input wire logic         reset_n_i,
  input wire logic         stop_task_i,
  input wire logic         end_event_o,
  input wire logic         match_event_o,
  input wire logic         no_match_event_o,
  input wire logic         dma_req_o,
  input wire logic [31:0]  dma_addr_o,
  input wire logic         dma_ack_i,
  input wire logic         aes_req_o,
  input wire logic [127:0] aes_key_o,
  input wire logic [127:0] aes_pt_o,
  input wire logic         aes_done_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic outc = match_event_o | no_match_event_o;
  AST_DMA_DONE: assert property ((outc || end_event_o) |-> !dma_req_o)
    else $error("dma busy at event");
  AST_DMA_HOLD:
    assert property (dma_req_o && !dma_ack_i |=> dma_req_o && $stable(dma_addr_o))
    else $error("dma request dropped");
  AST_ONE_OUT: assert property (!(match_event_o && no_match_event_o))
    else $error("two outcomes");
  AST_END_NEXT: assert property (outc |=> end_event_o)
    else $error("no end after outcome");
  AST_END_CAUSE: assert property (end_event_o |-> $past(outc))
    else $error("end without outcome");
  AST_AES_HOLD:
    assert property (aes_req_o && !aes_done_i |=> aes_req_o && $stable(aes_key_o))
    else $error("cipher request dropped");
  AST_AES_PT: assert property (aes_req_o |-> aes_pt_o[127:24] == 104'h0)
    else $error("plaintext pad wrong");
  AST_STEP:
    assert property (aes_req_o && aes_done_i && !stop_task_i |-> ##[1:4] (outc || dma_req_o))
    else $error("key walk stalled");
  cover property (match_event_o);
  cover property (no_match_event_o);
  cover property (dma_req_o && stop_task_i);
endmodule
bind par_resolver par_monitor u_mon (.*);
`default_nettype wire

// File: testbench/par_ram_model.sv
// ram and cipher stand-in on the resolver far side
`timescale 1ns/1ps
`default_nettype none
module par_ram_model (
  input  wire logic         clk_i,
  input  wire logic         slow_i,
  input  wire logic         req_i,
  input  wire logic [31:0]  addr_i,
  output logic              ack_o,
  output logic      [31:0]  rdata_o,
  input  wire logic         aes_req_i,
  input  wire logic [127:0] key_i,
  input  wire logic [127:0] pt_i,
  output logic              done_o,
  output logic      [127:0] ct_o
);
  logic [31:0] mem [128];
  logic [1:0]  cnt;
  initial
  begin
    ack_o = 1'b0;
    done_o = 1'b0;
    rdata_o = '0;
    ct_o = '0;
    cnt = '0;
  end
  // released data lines toggle, answers wait 0 or 3 extra cycles
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    done_o <= 1'b0;
    rdata_o <= ~rdata_o;
    ct_o <= ~ct_o;
    if ((req_i || aes_req_i) && !ack_o && !done_o)
    begin
      cnt <= cnt + 2'h1;
      if (!slow_i || cnt == 2'h3)
      begin
        cnt <= 2'h0;
        ack_o <= req_i;
        done_o <= aes_req_i;
        rdata_o <= mem[addr_i[8:2]];
        ct_o <= key_i ^ pt_i;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_par_resolver.sv
// self-checking bench for the private address resolver
`timescale 1ns/1ps
`default_nettype none
module tb_par_resolver;
  logic         clk_i = 0, reset_n_i = 0, reg_we_i = 0, reg_re_i = 0, slow = 0;
  logic         start_task_i = 0, stop_task_i = 0, end_event_o, match_event_o;
  logic         no_match_event_o, irq_o, dma_req_o, dma_ack_i, aes_req_o, aes_done_i;
  logic [11:0]  reg_addr_i = '0;
  logic [31:0]  reg_wdata_i = '0, reg_rdata_o, dma_addr_o, dma_rdata_i, top;
  logic [127:0] aes_key_o, aes_pt_o, aes_ct_i;
  int           fails = 0, n_tests = 0, cyc = 0, n_end, n_m, n_n;
  par_resolver u_dut (.*);
  par_ram_model u_ram (.clk_i(clk_i), .slow_i(slow), .req_i(dma_req_o), .addr_i(dma_addr_o),
    .ack_o(dma_ack_i), .rdata_o(dma_rdata_i), .aes_req_i(aes_req_o), .key_i(aes_key_o),
    .pt_i(aes_pt_o), .done_o(aes_done_i), .ct_o(aes_ct_i));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    n_end <= n_end + end_event_o;
    n_m <= n_m + match_event_o;
    n_n <= n_n + no_match_event_o;
    if (dma_ack_i && dma_addr_o > top)
      top <= dma_addr_o;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", w, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string w);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    chk(w, reg_rdata_o, e);
  endtask
  task automatic run(input logic pin);
    #1;
    n_end = 0;
    n_m = 0;
    n_n = 0;
    top = '0;
    if (pin)
    begin
      start_task_i <= 1'b1;
      @(posedge clk_i);
      start_task_i <= 1'b0;
    end
    else
      wr(par_pkg::OFF_START, 32'h1);
    for (int i = 0; i < 900 && n_end == 0; i++)
      @(posedge clk_i);
    repeat (2) @(posedge clk_i);
  endtask
  task automatic s_regs();
    rdchk(par_pkg::OFF_KEY_COUNT, 32'h1, "count");
    rdchk(par_pkg::OFF_LAST_KEY, 32'h0, "status");
    rdchk(12'h0fc, 32'h0, "unmapped");
    wr(par_pkg::OFF_IRQ_SET, 32'h7);
    wr(par_pkg::OFF_IRQ_CLR, 32'h2);
    rdchk(par_pkg::OFF_IRQ_SET, 32'h5, "irq set");
    rdchk(par_pkg::OFF_IRQ_CLR, 32'h5, "irq clr");
    run(1'b1);
    chk("off run", n_end + top, 32'h0);
    wr(par_pkg::OFF_ENABLE, 32'h3);
    wr(par_pkg::OFF_KEY_COUNT, 32'h11);
    rdchk(par_pkg::OFF_KEY_COUNT, 32'h1, "range");
    wr(par_pkg::OFF_KEY_PTR, 32'h40);
    wr(par_pkg::OFF_ADDR_PTR, 32'h0);
  endtask
  task automatic res(input int m, input int c, input logic pin, input logic sl);
    for (int n = 0; n < 16; n++)
      u_ram.mem[16 + 4 * n] = (n == m) ? 32'h005a5a5a : 32'(n);
    slow = sl;
    wr(par_pkg::OFF_KEY_COUNT, 32'(c));
    run(pin);
    chk("match", n_m, 32'(m < c));
    chk("nomatch", n_n, 32'(m >= c));
    chk("end", n_end, 32'h1);
    chk("last", top, 32'h4c + 32'(16 * ((m < c) ? m : c - 1)));
    if (m < c)
      rdchk(par_pkg::OFF_LAST_KEY, 32'(m), "index");
  endtask
  task automatic s_stop();
    slow = 1'b1;
    n_end = 0;
    n_m = 0;
    n_n = 0;
    wr(par_pkg::OFF_START, 32'h1);
    repeat (12) @(posedge clk_i);
    stop_task_i <= 1'b1;
    @(posedge clk_i);
    stop_task_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    chk("stop ev", n_end + n_m + n_n, 32'h0);
    chk("stop dma", dma_req_o, 1'b0);
  endtask
  task automatic s_flags();
    chk("irq on", irq_o, 1'b1);
    rdchk(par_pkg::OFF_EV_MATCH, 32'h1, "sticky");
    wr(par_pkg::OFF_EV_END, 32'h0);
    wr(par_pkg::OFF_EV_NOMATCH, 32'h0);
    rdchk(par_pkg::OFF_EV_END, 32'h0, "cleared");
    chk("irq off", irq_o, 1'b0);
  endtask
  initial
  begin
    for (int i = 0; i < 128; i++)
      u_ram.mem[i] = '0;
    u_ram.mem[0] = 32'h005a5a5a;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    s_regs();
    res(2, 4, 1'b0, 1'b0);
    res(15, 16, 1'b1, 1'b1);
    res(0, 16, 1'b1, 1'b0);
    s_stop();
    res(5, 3, 1'b1, 1'b0);
    s_flags();
    res(20, 16, 1'b0, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
